// [common/afs_pkg.sv]
package afs_pkg;

    // ==========================================================
    // register map, byte offsets of 32-bit words
    localparam logic [7:0] AFS_OFF_SC1 = 8'h00; // status_control_first
    localparam logic [7:0] AFS_OFF_SC2 = 8'h04; // status_control_second
    localparam logic [7:0] AFS_OFF_SC3 = 8'h08; // config_third
    localparam logic [7:0] AFS_OFF_SC4 = 8'h0C; // queue_config_fourth
    localparam logic [7:0] AFS_OFF_RH  = 8'h10; // result_high
    localparam logic [7:0] AFS_OFF_RL  = 8'h14; // result_low
    localparam logic [7:0] AFS_OFF_CVH = 8'h18; // compare value high
    localparam logic [7:0] AFS_OFF_CVL = 8'h1C; // compare value low

    // ==========================================================
    // field positions
    localparam int AFS_SC1_CONVERSION_COMPLETE_FLAG   = 7;
    localparam int AFS_SC2_HWTRG  = 6;
    localparam int AFS_SC2_CMPEN  = 5;
    localparam int AFS_SC2_CMPGT  = 4;
    localparam int AFS_SC4_SCAN   = 6;
    localparam int AFS_SC4_COMB   = 5;

    // ==========================================================
    // reset values and codes
    localparam logic [7:0] AFS_RST_SC1  = 8'h1F;
    localparam logic [7:0] AFS_RST_ZERO = 8'h00;
    localparam logic [4:0] AFS_CH_OFF   = 5'h1F;
    localparam logic [1:0] AFS_CLK_ASYNC = 2'h3;
    localparam int AFS_RES_W = 16;

    // ==========================================================
    // packed control fields
    typedef struct packed {
        logic       complete_irq_enable;
        logic       continuous_enable;
        logic [4:0] ch;
    } afs_sc1_t;

    typedef struct packed {
        logic       scan;
        logic       comb;
        logic [2:0] depth;
    } afs_sc4_t;

    typedef enum logic [2:0] {
        AFS_IDLE = 3'b001,
        AFS_WAIT = 3'b010,
        AFS_CONV = 3'b100
    } afs_state_t;

endpackage

// [hdl/afs_sequencer.sv]
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - nonzero depth field enables queue, max eight
// - separate channel queue and result queue
// - non-scan queued start waits until channel queue full
// - channel read returns active channel when queued
// - channel write pushes entry, aborts whole sequence
// - results come out in channel queue order
// - complete flag after whole queue, irq if enabled
// - software trigger fetches next channel immediately
// - hardware trigger fetch needs done, queued, pulse
// - single mode stops until refill or trigger
// - scan converts first entry, later writes overwrite
// - scan completes when result queue reaches depth
// - continuous restarts pass from first entry
// - wait mode keeps converting and starting
// - four conversion clocks usable in wait
// - completion interrupt wakes from wait mode
// - stop3 without async clock aborts to idle
// - stop3 with async clock keeps running
// - queued sequence need not run in stop3
// - config writes abort conversion and queue
// - queued compare stores data, flag by combine
module afs_sequencer #(
    parameter int DATA_W  = 12,
    parameter int QDEPTH  = 8
) (
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 hw_trigger,
    input  wire logic                 wait_mode,
    input  wire logic                 stop3_mode,
    input  wire logic                 conv_done,
    input  wire logic [DATA_W-1:0]    conv_result,
    output logic                      conv_start,
    output logic                      conv_abort,
    output logic      [4:0]           conv_channel,
    output logic      [1:0]           conv_clk_sel,
    output logic      [1:0]           conv_clk_div,
    output logic                      conv_long_sample,
    output logic                      conv_low_power,
    output logic      [1:0]           conv_mode,
    output logic                      irq
);
    import afs_pkg::*;

    // ==========================================================
    // registers
    afs_sc1_t                  sc1_q;
    afs_sc4_t                  sc4_q;
    logic [7:0]                sc2_q;
    logic [7:0]                sc3_q;
    logic [7:0]                cvh_q;
    logic [7:0]                cvl_q;
    logic                      conversion_complete_flag_q;
    logic                      ack_q;
    logic [31:0]               rdat_q;
    logic [4:0]                chan_mem [QDEPTH];
    logic [AFS_RES_W-1:0]      res_mem  [QDEPTH];
    logic [3:0]                fill_q;
    logic [2:0]                idx_q;
    logic [2:0]                res_wr_q;
    logic [2:0]                res_rd_q;
    logic                      armed_q;
    logic                      issued_q;
    logic                      any_q;
    logic                      all_q;
    logic                      start_q;
    logic                      abort_q;
    logic [4:0]                chan_q;
    logic                      irq_q;
    afs_state_t                state_q;

    // ==========================================================
    // decode
    logic                      fire;
    logic                      wr0;
    logic                      wr_sc1;
    logic                      wr_cfg;
    logic                      rd_rl;
    logic                      queued;
    logic [3:0]                depth_lv;
    logic                      hw_sel;
    logic                      cmp_en;
    logic                      stop3_abort;
    logic                      abort;
    logic                      new_seq;
    logic                      done_ok;
    logic                      last;
    logic                      seq_ready;
    logic [4:0]                cur_ch;
    logic [11:0]               cv;
    logic [AFS_RES_W-1:0]      res_ext;
    logic [AFS_RES_W-1:0]      cmp_diff;
    logic                      cmp_true;
    logic                      pass_flag;
    logic                      set_conversion_complete_flag;
    logic [AFS_RES_W-1:0]      res_out;

    assign fire     = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr0      = fire && wb_we_i && wb_sel_i[0];
    assign wr_sc1   = wr0 && (wb_adr_i == AFS_OFF_SC1);
    assign wr_cfg   = wr0 && ((wb_adr_i == AFS_OFF_SC2)
                      || (wb_adr_i == AFS_OFF_SC3)
                      || (wb_adr_i == AFS_OFF_SC4)
                      || (wb_adr_i == AFS_OFF_CVH)
                      || (wb_adr_i == AFS_OFF_CVL));
    assign rd_rl    = fire && !wb_we_i && (wb_adr_i == AFS_OFF_RL);
    assign queued   = (sc4_q.depth != 3'h0);
    assign depth_lv = {1'b0, sc4_q.depth} + 4'h1;
    assign hw_sel   = sc2_q[AFS_SC2_HWTRG];
    assign cmp_en   = sc2_q[AFS_SC2_CMPEN];
    // queued sequences are dropped in stop3 even on the async clock
    assign stop3_abort = stop3_mode && (state_q != AFS_IDLE)
                      && ((sc3_q[1:0] != AFS_CLK_ASYNC) || queued);
    assign abort    = wr_sc1 || wr_cfg || stop3_abort;
    // a full queue or a scan entry means the next write starts afresh
    assign new_seq  = sc4_q.scan || (fill_q == depth_lv);
    assign seq_ready = queued ? (sc4_q.scan ? (fill_q != 4'h0)
                                             : (fill_q == depth_lv))
                              : (sc1_q.ch != AFS_CH_OFF);
    assign cur_ch   = !queued ? sc1_q.ch
                    : (sc4_q.scan ? chan_mem[0] : chan_mem[idx_q]);
    assign done_ok  = (state_q == AFS_CONV) && issued_q && conv_done
                      && !abort;
    assign last     = ({1'b0, idx_q} == depth_lv - 4'h1);
    assign cv       = {cvh_q[3:0], cvl_q};
    assign res_ext  = AFS_RES_W'(conv_result);
    assign cmp_diff = res_ext - AFS_RES_W'(cv);
    assign cmp_true = sc2_q[AFS_SC2_CMPGT] ? (res_ext >= AFS_RES_W'(cv))
                                           : (res_ext <  AFS_RES_W'(cv));
    // OR combine: any pass true; AND combine: every pass true
    assign pass_flag = sc4_q.comb ? (all_q && cmp_true)
                                  : (any_q || cmp_true);
    assign set_conversion_complete_flag = done_ok && (queued
                      ? (last && (!cmp_en || pass_flag))
                      : (!cmp_en || cmp_true));
    assign res_out  = queued ? res_mem[res_rd_q] : res_mem[0];

    // ==========================================================
    // wishbone slave: answers one cycle after the request
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= fire;
            rdat_q <= 32'h0000_0000;
            if (fire && !wb_we_i) begin
                if (wb_adr_i == AFS_OFF_SC1) begin
                    rdat_q[7:0] <= {conversion_complete_flag_q, sc1_q.complete_irq_enable, sc1_q.continuous_enable,
                                    queued ? chan_q : sc1_q.ch};
                end else if (wb_adr_i == AFS_OFF_SC2) begin
                    rdat_q[7:0] <= sc2_q;
                end else if (wb_adr_i == AFS_OFF_SC3) begin
                    rdat_q[7:0] <= sc3_q;
                end else if (wb_adr_i == AFS_OFF_SC4) begin
                    rdat_q[7:0] <= {1'b0, sc4_q.scan, sc4_q.comb,
                                    2'h0, sc4_q.depth};
                end else if (wb_adr_i == AFS_OFF_RH) begin
                    rdat_q[7:0] <= res_out[15:8];
                end else if (wb_adr_i == AFS_OFF_RL) begin
                    rdat_q[7:0] <= res_out[7:0];
                end else if (wb_adr_i == AFS_OFF_CVH) begin
                    rdat_q[7:0] <= cvh_q;
                end else if (wb_adr_i == AFS_OFF_CVL) begin
                    rdat_q[7:0] <= cvl_q;
                end
            end
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sc1_q <= afs_sc1_t'(AFS_RST_SC1[6:0]);
            sc2_q <= AFS_RST_ZERO;
            sc3_q <= AFS_RST_ZERO;
            sc4_q <= afs_sc4_t'(AFS_RST_ZERO[4:0]);
            cvh_q <= AFS_RST_ZERO;
            cvl_q <= AFS_RST_ZERO;
        end else if (wr0) begin
            if (wb_adr_i == AFS_OFF_SC1) begin
                sc1_q <= afs_sc1_t'(wb_dat_i[6:0]);
            end else if (wb_adr_i == AFS_OFF_SC2) begin
                sc2_q <= wb_dat_i[7:0] & 8'h70;
            end else if (wb_adr_i == AFS_OFF_SC3) begin
                sc3_q <= wb_dat_i[7:0];
            end else if (wb_adr_i == AFS_OFF_SC4) begin
                sc4_q <= {wb_dat_i[AFS_SC4_SCAN], wb_dat_i[AFS_SC4_COMB],
                          wb_dat_i[2:0]};
            end else if (wb_adr_i == AFS_OFF_CVH) begin
                cvh_q <= wb_dat_i[7:0];
            end else if (wb_adr_i == AFS_OFF_CVL) begin
                cvl_q <= wb_dat_i[7:0];
            end
        end
    end

    // ==========================================================
    // channel queue fill and result read pointer
    always_ff @(posedge core_clk) begin
        if (wr_sc1 && queued) begin
            chan_mem[new_seq ? 3'h0 : fill_q[2:0]] <= wb_dat_i[4:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fill_q   <= 4'h0;
            res_rd_q <= 3'h0;
        end else if (wr_cfg) begin
            fill_q   <= 4'h0;
            res_rd_q <= 3'h0;
        end else if (wr_sc1 && queued) begin
            fill_q   <= new_seq ? 4'h1 : fill_q + 4'h1;
            if (new_seq || fill_q == 4'h0) begin
                res_rd_q <= 3'h0;
            end
        end else if (rd_rl && queued) begin
            res_rd_q <= res_rd_q + 3'h1;
        end
    end

    // ==========================================================
    // completion flag and interrupt
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            conversion_complete_flag_q <= 1'b0;
        end else if (set_conversion_complete_flag) begin
            conversion_complete_flag_q <= 1'b1;
        end else if (wr_sc1 || rd_rl) begin
            conversion_complete_flag_q <= 1'b0;
        end
    end

    // level request; wakes the core from wait or stop3 when enabled
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= conversion_complete_flag_q && sc1_q.complete_irq_enable;
        end
    end

    // ==========================================================
    // start request left by a channel write
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            armed_q <= 1'b0;
        end else if (wr_sc1) begin
            if (queued) begin
                armed_q <= sc4_q.scan
                        || (!new_seq && fill_q + 4'h1 == depth_lv);
            end else begin
                armed_q <= (wb_dat_i[4:0] != AFS_CH_OFF);
            end
        end else if (wr_cfg || stop3_abort) begin
            armed_q <= 1'b0;
        end else if (state_q == AFS_IDLE) begin
            armed_q <= 1'b0;
        end
    end

    // ==========================================================
    // sequencer; wait mode changes nothing here
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q  <= AFS_IDLE;
            issued_q <= 1'b0;
            idx_q    <= 3'h0;
            res_wr_q <= 3'h0;
            any_q    <= 1'b0;
            all_q    <= 1'b1;
        end else if (abort) begin
            state_q  <= AFS_IDLE;
            issued_q <= 1'b0;
            idx_q    <= 3'h0;
            res_wr_q <= 3'h0;
            any_q    <= 1'b0;
            all_q    <= 1'b1;
        end else begin
            case (state_q)
                AFS_IDLE: begin
                    if (armed_q) begin
                        state_q <= hw_sel ? AFS_WAIT : AFS_CONV;
                    end else if (hw_sel && hw_trigger && seq_ready) begin
                        state_q <= AFS_CONV;
                    end
                end
                AFS_WAIT: begin
                    if (hw_trigger) begin
                        state_q <= AFS_CONV;
                    end
                end
                AFS_CONV: begin
                    if (!issued_q) begin
                        issued_q <= 1'b1;
                    end else if (done_ok) begin
                        issued_q <= 1'b0;
                        if (queued && !last) begin
                            idx_q    <= idx_q + 3'h1;
                            res_wr_q <= res_wr_q + 3'h1;
                            any_q    <= any_q || cmp_true;
                            all_q    <= all_q && cmp_true;
                            state_q  <= hw_sel ? AFS_WAIT
                                               : AFS_CONV;
                        end else begin
                            idx_q    <= 3'h0;
                            res_wr_q <= 3'h0;
                            any_q    <= 1'b0;
                            all_q    <= 1'b1;
                            if (sc1_q.continuous_enable) begin
                                state_q <= hw_sel ? AFS_WAIT
                                                  : AFS_CONV;
                            end else begin
                                state_q <= AFS_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= AFS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // result store
    // queued compare keeps the difference whatever the outcome
    always_ff @(posedge core_clk) begin
        if (done_ok) begin
            if (queued) begin
                res_mem[res_wr_q] <= cmp_en ? cmp_diff : res_ext;
            end else if (!cmp_en) begin
                res_mem[0] <= res_ext;
            end else if (cmp_true) begin
                res_mem[0] <= cmp_diff;
            end
        end
    end

    // ==========================================================
    // converter core handshake
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
            chan_q  <= AFS_CH_OFF;
        end else begin
            start_q <= (state_q == AFS_CONV) && !issued_q && !abort;
            abort_q <= abort && (state_q != AFS_IDLE);
            if ((state_q == AFS_CONV) && !issued_q && !abort) begin
                chan_q <= cur_ch;
            end
        end
    end

    // ==========================================================
    // outputs
    assign wb_ack_o         = ack_q;
    assign wb_dat_o         = rdat_q;
    assign conv_start       = start_q;
    assign conv_abort       = abort_q;
    assign conv_channel     = chan_q;
    // all four clock choices pass through unchanged in wait mode
    assign conv_clk_sel     = sc3_q[1:0];
    assign conv_clk_div     = sc3_q[6:5];
    assign conv_long_sample = sc3_q[4];
    assign conv_low_power   = sc3_q[7];
    assign conv_mode        = sc3_q[3:2];
    assign irq              = irq_q;

endmodule

// [testbench/afs_sequencer_properties.sv]
`timescale 1ns/1ps
// ==========================================================
// bus and converter handshake checks
module afs_sequencer_properties (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        stop3_mode,
    input wire logic        conv_start,
    input wire logic        conv_abort,
    input wire logic [1:0]  conv_clk_sel,
    input wire logic        irq
);
    import afs_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire wr_seen = wb_ack_o && wb_we_i && wb_sel_i[0];
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not acked next cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    clock_choice_a: assert property (
        wr_seen && wb_adr_i == AFS_OFF_SC3
        |=> conv_clk_sel == $past(wb_dat_i[1:0]))
        else $error("clock select not taken from write");
    cfg_abort_a: assert property (
        wr_seen && wb_adr_i == AFS_OFF_SC2 |=> !conv_start [*3])
        else $error("start after mode write");
    stop_idle_a: assert property (stop3_mode && $past(stop3_mode)
        && $past(stop3_mode, 2) && conv_clk_sel != AFS_CLK_ASYNC
        |-> !conv_start) else $error("start while stopped");
    abort_nostart_a: assert property (conv_abort |-> !conv_start)
        else $error("start together with abort");
    cover property (conv_start);
    cover property (conv_abort);
    cover property ($rose(irq));
endmodule

// [testbench/tb_afs_sequencer.sv]
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
    errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module tb_afs_sequencer;
    import afs_pkg::*;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        hw_trigger = 1'b0;
    logic        stop3_mode = 1'b0;
    logic        conv_done = 1'b0;
    logic [11:0] conv_result = 12'h000;
    logic        conv_start, conv_abort;
    logic [4:0]  conv_channel, ch_q;
    logic [1:0]  clk_sel;
    logic [1:0]  clk_div, cmode;
    logic        lowp, lsmp;
    logic        irq;
    logic [7:0]  rq;
    logic [4:0]  ch_log[$];
    int          errors = 0;
    int          total_checks = 0;
    int          aborts = 0;
    int          cnt = 0;
    int          b;
    afs_sequencer dut (.core_clk(core_clk), .resetn(resetn),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .hw_trigger(hw_trigger), .wait_mode(1'b1), .stop3_mode(stop3_mode),
        .conv_done(conv_done), .conv_result(conv_result),
        .conv_start(conv_start), .conv_abort(conv_abort),
        .conv_channel(conv_channel), .conv_clk_sel(clk_sel),
        .conv_clk_div(clk_div), .conv_long_sample(lsmp),
        .conv_low_power(lowp), .conv_mode(cmode), .irq(irq));
    initial forever #10 core_clk = ~core_clk;
    // ==========================================================
    // converter core: fixed latency, result tagged by channel
    always @(posedge core_clk) begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result;
        if (conv_abort) begin
            aborts++;
            cnt <= 0;
        end else if (conv_start) begin
            ch_log.push_back(conv_channel);
            ch_q <= conv_channel;
            cnt <= 6;
        end else if (cnt == 1) begin
            conv_done <= 1'b1;
            conv_result <= {7'h50, ch_q};
            cnt <= 0;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    // ==========================================================
    // bus helpers
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        // no local limit: only the watchdog ends a stuck wait
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        rq = rdat[7:0];
        cyc <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 300 && irq !== 1'b1; n++) @(posedge core_clk);
    endtask
    task automatic pulse();
        @(posedge core_clk);
        hw_trigger <= 1'b1;
        @(posedge core_clk);
        hw_trigger <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        xfer(0, AFS_OFF_SC1, 0); `CHK("sc1", AFS_RST_SC1, rq)
        xfer(0, AFS_OFF_SC4, 0); `CHK("sc4", AFS_RST_ZERO, rq)
        xfer(0, 8'h20, 0); `CHK("unmapped", 8'h00, rq)
    endtask
    task automatic t_sw_queue();
        b = ch_log.size();
        xfer(1, AFS_OFF_SC4, 8'h01);
        xfer(1, AFS_OFF_SC1, 8'h03);
        idle(8); `CHK("early start", b, ch_log.size())
        xfer(1, AFS_OFF_SC1, 8'h45);
        wait_irq(); `CHK("irq", 1'b1, irq)
        `CHK("first ch", 5'd3, ch_log[b])
        xfer(0, AFS_OFF_RH, 0); `CHK("rh", 8'h0A, rq)
        xfer(0, AFS_OFF_RL, 0); `CHK("rl a", 8'h03, rq)
        xfer(0, AFS_OFF_RL, 0); `CHK("rl b", 8'h05, rq)
        idle(2); `CHK("irq clr", 1'b0, irq)
    endtask
    task automatic t_refill_abort();
        xfer(1, AFS_OFF_SC1, 8'h01);
        xfer(1, AFS_OFF_SC1, 8'h02);
        idle(2);
        b = aborts;
        xfer(1, AFS_OFF_SC1, 8'h05);
        idle(3); `CHK("refill abort", b + 1, aborts)
        b = ch_log.size();
        xfer(1, AFS_OFF_SC1, 8'h06);
        idle(30); `CHK("new seq", 5'd5, ch_log[b])
        `CHK("second", 5'd6, ch_log[b + 1])
    endtask
    task automatic t_hw();
        xfer(1, AFS_OFF_SC2, 8'h40);
        xfer(1, AFS_OFF_SC4, 8'h01);
        xfer(1, AFS_OFF_SC1, 8'h01);
        xfer(1, AFS_OFF_SC1, 8'h42);
        b = ch_log.size();
        idle(12); `CHK("no trigger", b, ch_log.size())
        pulse();
        idle(12); `CHK("one conv", b + 1, ch_log.size())
        pulse();
        wait_irq(); `CHK("hw irq", 1'b1, irq)
        idle(12); `CHK("stopped", b + 2, ch_log.size())
        xfer(1, AFS_OFF_SC2, 8'h00);
    endtask
    task automatic t_continuous();
        int n;
        xfer(1, AFS_OFF_SC1, 8'h06);
        b = ch_log.size();
        xfer(1, AFS_OFF_SC1, 8'h27);
        for (n = 0; n < 200 && ch_log.size() < b + 4; n++) idle(1);
        `CHK("pass1 a", 5'd6, ch_log[b])
        `CHK("pass2 a", 5'd6, ch_log[b + 2])
        `CHK("pass2 b", 5'd7, ch_log[b + 3])
        xfer(1, AFS_OFF_SC2, 8'h00);
    endtask
    task automatic t_scan();
        xfer(1, AFS_OFF_SC4, 8'h41);
        b = ch_log.size();
        xfer(1, AFS_OFF_SC1, 8'h09);
        idle(40); `CHK("scan count", b + 2, ch_log.size())
        `CHK("scan ch", 5'd9, ch_log[b + 1])
        xfer(0, AFS_OFF_SC1, 0); `CHK("scan conversion_complete_flag", 1'b1, rq[7])
        `CHK("scan rd ch", 5'd9, rq[4:0])
    endtask
    task automatic t_single_abort();
        xfer(1, AFS_OFF_SC3, 8'hF5);
        `CHK("sc3 out", 8'hF5, {lowp, clk_div, lsmp, cmode, clk_sel})
        xfer(1, AFS_OFF_SC4, 8'h00);
        xfer(1, AFS_OFF_SC1, 8'h04);
        idle(2);
        b = aborts;
        stop3_mode <= 1'b1;
        idle(4); `CHK("stop abort", b + 1, aborts)
        stop3_mode <= 1'b0;
        b = ch_log.size();
        idle(10); `CHK("no resume", b, ch_log.size())
        xfer(1, AFS_OFF_SC1, 8'h04);
        idle(2);
        b = aborts;
        xfer(1, AFS_OFF_SC3, 8'h02);
        idle(3); `CHK("cfg abort", b + 1, aborts)
    endtask
    // results 0xA01 (below limit) and 0xA03 (at or above limit 0xA02)
    task automatic t_compare();
        xfer(1, AFS_OFF_SC4, 8'h01);
        xfer(1, AFS_OFF_SC2, 8'h30);
        xfer(1, AFS_OFF_CVH, 8'h0A);
        xfer(1, AFS_OFF_CVL, 8'h02);
        xfer(1, AFS_OFF_SC1, 8'h01);
        xfer(1, AFS_OFF_SC1, 8'h43);
        wait_irq(); `CHK("cmp irq", 1'b1, irq)
        xfer(0, AFS_OFF_RH, 0); `CHK("cmp rh a", 8'hFF, rq)
        xfer(0, AFS_OFF_RL, 0); `CHK("cmp rl a", 8'hFF, rq)
        xfer(0, AFS_OFF_RH, 0); `CHK("cmp rh b", 8'h00, rq)
        xfer(0, AFS_OFF_RL, 0); `CHK("cmp rl b", 8'h01, rq)
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_sw_queue();
        t_refill_abort();
        t_hw();
        t_continuous();
        t_scan();
        t_single_abort();
        t_compare();
        end_of_test();
    end
    // ratio: tests need roughly 400 cycles, watchdog at 20000
    initial begin
        #(20 * 20000);
        errors++;
        end_of_test();
    end
endmodule
bind afs_sequencer afs_sequencer_properties u_props (
    .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .stop3_mode(stop3_mode), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_clk_sel(conv_clk_sel), .irq(irq));
